// ==== hw/epp_gateway_pkg.sv ====
// Purpose: Constants and types shared by the parallel-port register gateway
// Assumes: Single 10 MHz clock; port strobes are sampled as synchronous inputs
// Notes:   The behaviour list below is the reference for the tags in the design
// Behaviour
// - Address write stores current register address
// - Data write loads addressed register
// - Data read returns addressed register
// - Address read returns pending event mask
// - Mask eight bits, cleared by its read
// - Event sources share one interrupt line
// - Holdoff cycles between successive interrupts
// - Re-signal pending interrupt every holdoff interval
// - Register bank exposed continuously to sequencer
// - Write pulses register update flag once
// - All registers handled alike, uninterpreted
// - Drive data lines only during reads
// - Port reset resets firmware and USB chip
// - Configuration unused until activation command
// - Configuration interrupt answered by one byte
// - Interrupts repeat until queue full
// - Write, strobes and wait are active low
// - One internal strobe per host strobe
// - Wait rises one to two cycles after strobe; wait_o here rises four cycles after the strobe falls
// - Direction is one for reads, zero writes
package epp_gateway_pkg;

    localparam int CLOCK_HZ       = 10_000_000;
    localparam int DATA_W         = 8;
    localparam int MASK_W         = 8;
    localparam int REG_COUNT      = 16;
    localparam int ADDR_W         = 8;
    localparam int SEL_W          = $clog2(REG_COUNT);
    localparam int HOLDOFF_W      = 16;
    localparam int RESET_SYNC_LEN = 2;

    localparam logic [DATA_W-1:0]    REG_RESET  = 8'h00;
    localparam logic [ADDR_W-1:0]    ADDR_RESET = 8'h00;
    localparam logic [MASK_W-1:0]    MASK_RESET = 8'h00;

    // Kind of transaction held while the strobe is serviced
    typedef enum logic [1:0]
    {
        CYCLE_ADDR_WRITE,
        CYCLE_ADDR_READ,
        CYCLE_DATA_WRITE,
        CYCLE_DATA_READ
    } cycle_kind_t;

    // Index of the bank entry picked by the stored address
    function automatic logic [SEL_W-1:0] reg_select(input logic [ADDR_W-1:0] addr);
        reg_select = addr[SEL_W-1:0];
    endfunction

    // Address lies inside the implemented bank
    function automatic logic reg_in_range(input logic [ADDR_W-1:0] addr);
        reg_in_range = (addr < ADDR_W'(REG_COUNT));
    endfunction

endpackage

// ==== hw/epp_handshaker.sv ====
// Purpose: Retimes port strobes, produces one internal strobe and the wait line
// Assumes: Write line is stable before a strobe falls and until wait rises
// Notes:   Strobes are registered twice; only the second stage feeds logic
`timescale 1ns/1ns
module epp_handshaker
(
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic enable_i,
    input  wire logic write_n_i,
    input  wire logic data_strobe_n_i,
    input  wire logic addr_strobe_n_i,
    output logic      strobe_o,
    output logic      is_addr_o,
    output logic      send_o,
    output logic      wait_o
);
    import epp_gateway_pkg::*;

    logic data_meta;
    logic addr_meta;
    logic data_act;
    logic addr_act;
    logic armed;

    // Two stages on each strobe; first stage read only by the second
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            data_meta <= 1'b0;
            addr_meta <= 1'b0;
            data_act  <= 1'b0;
            addr_act  <= 1'b0;
        end
        else if (enable_i)
        begin
            data_meta <= ~data_strobe_n_i;
            addr_meta <= ~addr_strobe_n_i;
            data_act  <= data_meta;
            addr_act  <= addr_meta;
        end
    end

    // One strobe per host strobe; rearmed once both strobes are released
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            strobe_o  <= 1'b0;
            armed     <= 1'b1;
            is_addr_o <= 1'b0;
            send_o    <= 1'b0;
        end
        else if (enable_i)
        begin
            strobe_o <= 1'b0;
            if (armed && (data_act || addr_act))
            begin
                strobe_o  <= 1'b1;
                armed     <= 1'b0;
                is_addr_o <= addr_act;
                send_o    <= write_n_i;
            end
            else if (!data_act && !addr_act)
            begin
                armed <= 1'b1;
            end
        end
    end

    // Wait goes high with the internal strobe, falls when strobes release
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_o <= 1'b0;
        end
        else if (enable_i)
        begin
            if (armed && (data_act || addr_act))
            begin
                wait_o <= 1'b1;
            end
            else if (!data_act && !addr_act)
            begin
                wait_o <= 1'b0;
            end
        end
    end

endmodule

// ==== hw/epp_interrupter.sv ====
// Purpose: Collects event requests into a mask and paces the interrupt line
// Assumes: Host acknowledges with an address read, which clears the mask
// Notes:   A request arriving during the clearing read is kept
`timescale 1ns/1ns
module epp_interrupter
#(
    parameter int MASK_WIDTH = epp_gateway_pkg::MASK_W,
    parameter int HOLD_WIDTH = epp_gateway_pkg::HOLDOFF_W
)
(
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  enable_i,
    input  wire logic [MASK_WIDTH-1:0] event_i,
    input  wire logic [HOLD_WIDTH-1:0] holdoff_i,
    input  wire logic                  mask_read_i,
    output logic [MASK_WIDTH-1:0]      mask_o,
    output logic                       irq_o
);
    import epp_gateway_pkg::*;

    logic [HOLD_WIDTH-1:0] gap_count;
    logic                  next_irq;

    // Sticky mask; set beats the read clear
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mask_o <= MASK_RESET;
        end
        else if (enable_i)
        begin
            if (mask_read_i)
            begin
                mask_o <= event_i;
            end
            else
            begin
                mask_o <= mask_o | event_i;
            end
        end
    end

    // Fire when anything pends and the holdoff gap has elapsed
    assign next_irq = (|mask_o) && !mask_read_i && (gap_count == '0);

    // Holdoff counter restarts on every interrupt, giving the resend rate
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_o     <= 1'b0;
            gap_count <= '0;
        end
        else if (enable_i)
        begin
            irq_o <= next_irq;
            if (next_irq)
            begin
                gap_count <= holdoff_i;
            end
            else if (gap_count != '0)
            begin
                gap_count <= gap_count - 1'b1;
            end
        end
    end

endmodule

// ==== hw/epp_register_gateway.sv ====
// Purpose: Bridges the parallel-port EPP cycles onto a bank of 8-bit registers
// Assumes: Strobes and write line come from the host; one clock of 10 MHz
// Notes:   Contents are not interpreted here; the sequencer decides meaning
`timescale 1ns/1ns
module epp_register_gateway
#(
    parameter int REGS = epp_gateway_pkg::REG_COUNT
)
(
    input  wire logic                                 clock_i,
    input  wire logic                                 rst_n_i,
    input  wire logic                                 enable_i,
    input  wire logic                                 port_reset_n_i,
    input  wire logic                                 write_n_i,
    input  wire logic                                 data_strobe_n_i,
    input  wire logic                                 addr_strobe_n_i,
    input  wire logic [epp_gateway_pkg::DATA_W-1:0]   data_i,
    input  wire logic [epp_gateway_pkg::MASK_W-1:0]   event_i,
    input  wire logic [epp_gateway_pkg::HOLDOFF_W-1:0] holdoff_i,
    output logic [epp_gateway_pkg::DATA_W-1:0]        data_o,
    output logic                                      data_oe_o,
    output logic                                      xcvr_drive_o,
    output logic                                      wait_o,
    output logic                                      irq_o,
    output logic                                      firmware_reset_o,
    output logic                                      usb_reset_n_o,
    output logic [REGS*epp_gateway_pkg::DATA_W-1:0]   regs_o,
    output logic [REGS-1:0]                           attn_o
);
    import epp_gateway_pkg::*;

    logic                  strobe;
    logic                  is_addr;
    logic                  send;
    logic                  hs_wait;
    logic [MASK_W-1:0]     mask;
    logic                  irq;
    logic                  mask_read;
    logic [ADDR_W-1:0]     cur_addr;
    logic [DATA_W-1:0]     bank [REGS];
    logic                  port_meta;
    logic                  port_sync;
    cycle_kind_t           kind;

    // Retiming and handshake for the host strobes
    epp_handshaker u_handshaker
    (
        .clock_i         (clock_i),
        .rst_n_i         (rst_n_i),
        .enable_i        (enable_i),
        .write_n_i       (write_n_i),
        .data_strobe_n_i (data_strobe_n_i),
        .addr_strobe_n_i (addr_strobe_n_i),
        .strobe_o        (strobe),
        .is_addr_o       (is_addr),
        .send_o          (send),
        .wait_o          (hs_wait)
    );

    // Shared interrupt with holdoff and resend
    epp_interrupter u_interrupter
    (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .enable_i    (enable_i),
        .event_i     (event_i),
        .holdoff_i   (holdoff_i),
        .mask_read_i (mask_read),
        .mask_o      (mask),
        .irq_o       (irq)
    );

    // Decode the serviced transaction from the settled direction flags
    always_comb
    begin
        unique case ({is_addr, send})
            2'b10:   kind = CYCLE_ADDR_WRITE;
            2'b11:   kind = CYCLE_ADDR_READ;
            2'b00:   kind = CYCLE_DATA_WRITE;
            2'b01:   kind = CYCLE_DATA_READ;
        endcase
    end

    assign mask_read = strobe && (kind == CYCLE_ADDR_READ);

    // Port reset synchroniser; held reset clears the address, bank and update flags and drives both reset outputs
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            port_meta <= 1'b1;
            port_sync <= 1'b1;
        end
        else if (enable_i)
        begin
            port_meta <= ~port_reset_n_i;
            port_sync <= port_meta;
        end
    end

    // Firmware and USB chip resets follow the port reset line
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            firmware_reset_o <= 1'b1;
            usb_reset_n_o    <= 1'b0;
        end
        else if (enable_i)
        begin
            firmware_reset_o <= port_sync;
            usb_reset_n_o    <= ~port_sync;
        end
    end

    // Current register address taken on address writes
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cur_addr <= ADDR_RESET;
        end
        else if (enable_i)
        begin
            if (port_sync)
            begin
                cur_addr <= ADDR_RESET;
            end
            else if (strobe && kind == CYCLE_ADDR_WRITE)
            begin
                cur_addr <= data_i;
            end
        end
    end

    // Register bank: every entry treated alike; writes outside the bank drop
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < REGS; i++)
            begin
                bank[i] <= REG_RESET;
            end
        end
        else if (enable_i)
        begin
            if (port_sync)
            begin
                for (int i = 0; i < REGS; i++)
                begin
                    bank[i] <= REG_RESET;
                end
            end
            else if (strobe && kind == CYCLE_DATA_WRITE && reg_in_range(cur_addr))
            begin
                bank[reg_select(cur_addr)] <= data_i;
            end
        end
    end

    // Update flags for the sequencer, one cycle, a cycle before regs_o shows the new value
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            attn_o <= '0;
        end
        else if (enable_i)
        begin
            attn_o <= '0;
            if (!port_sync && strobe && kind == CYCLE_DATA_WRITE
                && reg_in_range(cur_addr))
            begin
                attn_o[reg_select(cur_addr)] <= 1'b1;
            end
        end
    end

    // Registered copy of the bank for the sequencer
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            regs_o <= '0;
        end
        else if (enable_i)
        begin
            for (int i = 0; i < REGS; i++)
            begin
                regs_o[i*DATA_W +: DATA_W] <= bank[i];
            end
        end
    end

    // Read data: mask for address reads, register for data reads
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            data_o <= '0;
        end
        else if (enable_i && strobe)
        begin
            if (kind == CYCLE_ADDR_READ)
            begin
                data_o <= mask;
            end
            else if (kind == CYCLE_DATA_READ)
            begin
                // Out-of-bank addresses read as zero
                data_o <= reg_in_range(cur_addr) ? bank[reg_select(cur_addr)] : '0;
            end
        end
    end

    // Drive only while a read cycle is being answered, avoiding contention
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            data_oe_o    <= 1'b0;
            xcvr_drive_o <= 1'b0;
        end
        else if (enable_i)
        begin
            data_oe_o    <= send && hs_wait_next();
            xcvr_drive_o <= send && hs_wait_next();
        end
    end

    // Wait and interrupt are re-registered so outputs come from flops
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_o <= 1'b0;
            irq_o  <= 1'b0;
        end
        else if (enable_i)
        begin
            wait_o <= hs_wait;
            irq_o  <= irq;
        end
    end

    // Transaction in progress: strobe seen or wait still high
    function automatic logic hs_wait_next();
        hs_wait_next = strobe || hs_wait;
    endfunction

endmodule

// ==== verif/epp_host_model.sv ====
// Purpose: Host side of the parallel port, one EPP cycle per call
// Assumes: Signals change just after a rising edge and hold until wait
// Notes:   Undriven data lines show the inverse of the last host byte
`timescale 1ns/1ns
module epp_host_model
(
    input  wire logic       clock_i,
    input  wire logic       wait_i,
    input  wire logic       drive_i,
    input  wire logic [7:0] dev_data_i,
    output logic            write_n_o,
    output logic            data_strobe_n_o,
    output logic            addr_strobe_n_o,
    output logic [7:0]      line_o
);
    logic       own      = 1'b0;
    logic [7:0] hdat     = 8'h00;
    int         timeouts = 0;

    // Wire level; a released bus must not look like held data
    assign line_o = drive_i ? dev_data_i : (own ? hdat : ~hdat);

    initial
    begin
        write_n_o       = 1'b1;
        data_strobe_n_o = 1'b1;
        addr_strobe_n_o = 1'b1;
    end

    // One transfer; an address read also answers an interrupt
    task automatic xfer(input logic a, input logic rd, input logic [7:0] wd,
                        output logic [7:0] rdat);
        @(posedge clock_i);
        write_n_o <= rd;
        hdat      <= wd;
        own       <= !rd;
        if (a)
            addr_strobe_n_o <= 1'b0;
        else
            data_strobe_n_o <= 1'b0;
        repeat (20) if (!wait_i) @(posedge clock_i);
        if (!wait_i)
            timeouts++;
        rdat = dev_data_i;
        addr_strobe_n_o <= 1'b1;
        data_strobe_n_o <= 1'b1;
        own             <= 1'b0;
        // Write line held until wait drops, as the protocol promises
        repeat (20) if (wait_i) @(posedge clock_i);
        if (wait_i)
            timeouts++;
        write_n_o <= 1'b1;
    endtask
endmodule

// ==== verif/epp_gateway_checker.sv ====
// Purpose: Port-level assertions for the register gateway
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Holdoff is expected to stay below the gap counter range
`timescale 1ns/1ns
module epp_gateway_checker
#(
    parameter int REGS = epp_gateway_pkg::REG_COUNT
)
(
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        port_reset_n_i,
    input wire logic        write_n_i,
    input wire logic        data_strobe_n_i,
    input wire logic        addr_strobe_n_i,
    input wire logic [15:0] holdoff_i,
    input wire logic        data_oe_o,
    input wire logic        xcvr_drive_o,
    input wire logic        wait_o,
    input wire logic        irq_o,
    input wire logic        firmware_reset_o,
    input wire logic        usb_reset_n_o,
    input wire logic [REGS-1:0] attn_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    logic        idle;
    logic [15:0] gap;
    logic        seen;
    assign idle = data_strobe_n_i & addr_strobe_n_i;

    // Cycles since the last interrupt pulse, saturating
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gap  <= 16'h0000;
            seen <= 1'b0;
        end
        else
        begin
            gap  <= irq_o ? 16'h0001 : (gap == 16'hffff ? gap : gap + 16'h0001);
            seen <= seen | irq_o;
        end
    end

    sequence host_strobe;
        $fell(idle);
    endsequence
    // Strobe is seen low at the first edge, then two retiming stages,
    // the internal strobe and the output flop: wait is sampled high at the fifth
    sequence ack_rise;
        ##4 wait_o;
    endsequence

    wait_rise_a: assert property (host_strobe |-> ack_rise) else $error("wait late");
    wait_hold_a: assert property (wait_o && !idle |=> wait_o) else $error("wait dropped");
    drive_read_a: assert property (data_oe_o |-> write_n_i) else $error("drive in write");
    xcvr_match_a: assert property (xcvr_drive_o == data_oe_o) else $error("xcvr differs");
    attn_pulse_a: assert property (attn_o != '0 |-> $onehot(attn_o) ##1 attn_o == '0)
        else $error("attn not one pulse");
    attn_cause_a: assert property (attn_o != '0 |-> wait_o && !write_n_i && !data_strobe_n_i)
        else $error("attn without write");
    irq_pulse_a: assert property (irq_o |=> !irq_o) else $error("irq too long");
    irq_gap_a: assert property (irq_o && seen |-> gap > holdoff_i) else $error("irq early");
    fw_reset_a: assert property (!port_reset_n_i [*4] |-> firmware_reset_o)
        else $error("no fw reset");
    usb_reset_a: assert property (usb_reset_n_o == !firmware_reset_o)
        else $error("usb reset");
endmodule

bind epp_register_gateway epp_gateway_checker #(.REGS(REGS)) check_u
(
    .clock_i(clock_i), .rst_n_i(rst_n_i), .port_reset_n_i(port_reset_n_i),
    .write_n_i(write_n_i), .data_strobe_n_i(data_strobe_n_i),
    .addr_strobe_n_i(addr_strobe_n_i), .holdoff_i(holdoff_i), .data_oe_o(data_oe_o),
    .xcvr_drive_o(xcvr_drive_o), .wait_o(wait_o), .irq_o(irq_o),
    .firmware_reset_o(firmware_reset_o), .usb_reset_n_o(usb_reset_n_o), .attn_o(attn_o)
);

// ==== verif/epp_register_gateway_test.sv ====
// Purpose: Self-checking bench for the register gateway
// Assumes: Host model performs every port handshake
// Notes:   Random bytes from a fixed seed; holdoff kept small for speed
`timescale 1ns/1ns
module epp_register_gateway_test;
    import epp_gateway_pkg::*;
    localparam int REGS = REG_COUNT;
    localparam logic [HOLDOFF_W-1:0] HOLD = 16'h0005;

    logic                   clock_i = 1'b0;
    logic                   rst_n_i = 1'b0;
    logic                   port_reset_n_i = 1'b1;
    logic [MASK_W-1:0]      event_i = 8'h00;
    logic                   write_n, data_strobe_n, addr_strobe_n;
    logic                   data_oe_o, xcvr_drive_o, wait_o, irq_o, fw_reset, usb_reset_n;
    logic [DATA_W-1:0]      line, data_o, rd, d;
    logic [REGS*DATA_W-1:0] regs_o;
    logic [REGS-1:0]        attn_o;
    logic [DATA_W-1:0]      expect_reg [REGS];
    int                     fail_count = 0, n_compared = 0, seed = 25422, n, k;

    always #50 clock_i = ~clock_i;

    epp_register_gateway #(.REGS(REGS)) dut_u
    (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .enable_i(1'b1),
        .port_reset_n_i(port_reset_n_i), .write_n_i(write_n),
        .data_strobe_n_i(data_strobe_n), .addr_strobe_n_i(addr_strobe_n),
        .data_i(line), .event_i(event_i), .holdoff_i(HOLD), .data_o(data_o),
        .data_oe_o(data_oe_o), .xcvr_drive_o(xcvr_drive_o), .wait_o(wait_o),
        .irq_o(irq_o), .firmware_reset_o(fw_reset), .usb_reset_n_o(usb_reset_n),
        .regs_o(regs_o), .attn_o(attn_o)
    );

    epp_host_model host_u
    (
        .clock_i(clock_i), .wait_i(wait_o), .drive_i(data_oe_o), .dev_data_i(data_o),
        .write_n_o(write_n), .data_strobe_n_o(data_strobe_n),
        .addr_strobe_n_o(addr_strobe_n), .line_o(line)
    );

    task automatic check(input logic [REGS*DATA_W-1:0] seen, input logic [REGS*DATA_W-1:0] want,
                         input string what);
        n_compared++;
        if (seen !== want)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic put(input logic a, input logic [7:0] v);
        logic [7:0] ignored;
        host_u.xfer(a, 1'b0, v, ignored);
    endtask

    task automatic get(input logic a, output logic [7:0] v);
        host_u.xfer(a, 1'b1, 8'h00, v);
    endtask

    // Counts edges until an interrupt pulse is sampled
    task automatic wait_irq(output int i);
        i = 0;
        do
        begin
            @(posedge clock_i);
            i++;
        end
        while (irq_o !== 1'b1 && i < 200);
        check(i < 200, 1'b1, "irq missing");
    endtask

    // Expected bank contents, packed as the design presents them
    function automatic logic [REGS*DATA_W-1:0] bank_image();
        logic [REGS*DATA_W-1:0] img;
        for (int i = 0; i < REGS; i++)
            img[i*DATA_W +: DATA_W] = expect_reg[i];
        return img;
    endfunction

    task automatic complete_run();
        $display("Compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        for (k = 0; k < REGS; k++)
            expect_reg[k] = 8'h00;
        repeat (10) @(posedge clock_i);
        check(fw_reset, 1'b1, "reset held");
        rst_n_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        check(fw_reset, 1'b0, "reset release");
        // Every register gets a random byte; no other entry may move
        for (k = 0; k < REGS; k++)
        begin
            d = 8'($random(seed));
            put(1'b1, 8'(k));
            put(1'b0, d);
            expect_reg[k] = d;
            check(regs_o, bank_image(), "bank write");
        end
        // Reverse order so a stale address would show
        for (k = REGS - 1; k >= 0; k--)
        begin
            put(1'b1, 8'(k));
            get(1'b0, rd);
            check(rd, expect_reg[k], "read back");
        end
        // Unmapped address: write dropped, read gives zero
        d = 8'($random(seed));
        put(1'b1, d | 8'h10);
        put(1'b0, d);
        get(1'b0, rd);
        check(rd, 8'h00, "unmapped read");
        check(regs_o, bank_image(), "unmapped write");
        // Address once, then several data writes to one register
        put(1'b1, 8'h03);
        repeat (3)
        begin
            d = 8'($random(seed));
            put(1'b0, d);
            expect_reg[3] = d;
        end
        check(regs_o, bank_image(), "repeat writes");
        // Sources in two cycles; unanswered request comes back
        d = 8'($random(seed)) | 8'h01;
        @(posedge clock_i);
        event_i <= d & 8'h0f;
        @(posedge clock_i);
        event_i <= d & 8'hf0;
        @(posedge clock_i);
        event_i <= 8'h00;
        wait_irq(n);
        wait_irq(n);
        check(n, HOLD + 1, "re-signal gap");
        get(1'b1, rd);
        check(rd, d, "event mask");
        get(1'b1, rd);
        check(rd, 8'h00, "mask cleared");
        // Event lands on the edge that clears the mask
        fork
            get(1'b1, rd);
            begin
                repeat (4) @(posedge clock_i);
                event_i <= 8'h80;
                @(posedge clock_i);
                event_i <= 8'h00;
            end
        join
        get(1'b1, rd);
        check(rd, 8'h80, "kept event");
        // Port reset clears the bank and drives both reset outputs
        @(posedge clock_i);
        port_reset_n_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        check({fw_reset, usb_reset_n}, 2'b10, "port reset");
        port_reset_n_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        for (k = 0; k < REGS; k++)
            expect_reg[k] = 8'h00;
        check(regs_o, bank_image(), "bank cleared");
        check(host_u.timeouts, 0, "handshake timeout");
        complete_run();
    end

    // Far beyond the fewer than a thousand cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        complete_run();
    end
endmodule
